// *** iir_host_model.sv ***
`timescale 1ns/1ns
module iir_host_model #(
  parameter int unsigned NUM_LINES = 8
) (
  // Board drive
  input wire logic [NUM_LINES-1:0] irq_o,
  input wire logic [NUM_LINES-1:0] irq_oe,
  // Resolved host lines
  output logic [NUM_LINES-1:0] irq_line
);
  // A released line falls to its inactive low level through the host pull resistor.
  assign irq_line = irq_oe & irq_o;
endmodule

// *** iir_in_sync.sv ***
`timescale 1ns/1ns
module iir_in_sync #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Lines
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A bit moves only once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (!reset_n)
          level_out[g] <= 1'h0;
        else if (stage2_reg[g] == stage3_reg[g])
          level_out[g] <= stage3_reg[g];
      end
    end
  endgenerate

endmodule

// *** iir_pkg.sv ***
package iir_pkg;

  localparam int unsigned NUM_INPUTS = 16;
  localparam int unsigned NUM_LINES = 8;
  localparam int unsigned SEL_W = 3;

  // Byte offsets of the word registers, relative to the board base.
  localparam logic [4:0] OFS_GLOBAL_GROUP_CONTROL = 5'h02;
  localparam logic [4:0] OFS_GROUP_IRQ_SELECT = 5'h04;
  localparam logic [4:0] OFS_PER_INPUT_IRQ_GATE = 5'h06;
  localparam logic [4:0] OFS_SINGLE_IRQ_SELECT_0 = 5'h08;
  localparam logic [4:0] OFS_SINGLE_IRQ_SELECT_1 = 5'h0a;
  localparam logic [4:0] OFS_SINGLE_IRQ_SELECT_2 = 5'h0c;
  localparam logic [4:0] OFS_IRQ_ENABLE_LOW = 5'h0e;
  localparam logic [4:0] OFS_IRQ_ENABLE_HIGH = 5'h10;
  localparam logic [4:0] OFS_PER_INPUT_LATCH_RESET = 5'h12;
  localparam logic [4:0] OFS_DIGITAL_IO_PORT = 5'h14;
  localparam logic [4:0] OFS_LATCH_STATUS = 5'h1c;
  localparam logic [4:0] OFS_INPUT_LEVEL = 5'h1e;

  // Field positions.
  localparam int unsigned BIT_LOW_GROUP_LATCH_RESET = 0;
  localparam int unsigned BIT_HIGH_GROUP_LATCH_RESET = 1;
  localparam int unsigned POS_LOW_GROUP_SEL = 0;
  localparam int unsigned BIT_LOW_GROUP_EN = 3;
  localparam int unsigned POS_HIGH_GROUP_SEL = 4;
  localparam int unsigned BIT_HIGH_GROUP_EN = 7;

  // Reset values.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_LATCH_RESET = 16'hffff;
  localparam logic [15:0] RST_GLOBAL = 16'h0000;

  // One host I/O cycle, held for a single clock.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } iir_io_req_t;

endpackage

// *** iir_router.sv ***
`timescale 1ns/1ns
// Function
// - Eight host interrupt request lines serve as routing targets.
// - Inputs not routed singly may share one group line in shared mode.
// - Each gated input drives the line picked by the three select registers.
// - Rising edge on an enabled input that is gated or in shared mode sets its latch and asserts its line.
// - Each input latch can be cleared alone through the latch reset register.
// - Writing 0 then 1 to global bit 0 or bit 1 clears low or high latches.
// - Sixteen digital inputs and outputs share one register at offset 20.
// - Word write drives the outputs; word read returns the input lines.
// - Each input latch drives requests in normal mode, shared mode or both.
// - Two enable registers switch board interrupt generation on and off.
// - Writing zero to the gate register turns off individual mode for all.
// - Writing 0 then 1 to an input's latch reset bit clears that latch.
// - Gate, group mux and global control registers reset to zero.
module iir_router #(
  parameter int unsigned NUM_INPUTS = iir_pkg::NUM_INPUTS,
  parameter int unsigned NUM_LINES = iir_pkg::NUM_LINES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Host I/O cycle
  input wire iir_pkg::iir_io_req_t io_req,
  output logic [15:0] io_rdata,
  output logic io_rvalid,
  // Isolated inputs
  input wire logic [NUM_INPUTS-1:0] iso_in,
  // Digital port lines
  input wire logic [15:0] dig_in,
  output logic [15:0] dig_out,
  // Host interrupt request lines, open collector
  output logic [NUM_LINES-1:0] irq_o,
  output logic [NUM_LINES-1:0] irq_oe
);

  localparam int unsigned HALF = NUM_INPUTS / 2;

  // Inputs below HALF form the low group and the rest the high group; each group
  // has one shared line, one group clear bit and one enable register of its own.

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [NUM_INPUTS-1:0] iso_level;
  logic [15:0] dig_level;
  logic [NUM_INPUTS-1:0] iso_prev_reg;
  logic [NUM_INPUTS-1:0] iso_rise;

  iir_in_sync #(
    .WIDTH(NUM_INPUTS)
  ) u_iso_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in(iso_in),
    .level_out(iso_level)
  );

  iir_in_sync #(
    .WIDTH(16)
  ) u_dig_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in(dig_in),
    .level_out(dig_level)
  );

  // The previous level resets to the idle low level of the pins, so leaving
  // reset never shows a false rising edge.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      iso_prev_reg <= '0;
    else
      iso_prev_reg <= iso_level;
  end

  assign iso_rise = iso_level & ~iso_prev_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [15:0] global_group_control_reg;
  logic [15:0] group_irq_select_reg;
  logic [15:0] per_input_irq_gate_reg;
  logic [47:0] single_irq_select_reg;
  logic [15:0] irq_enable_low_reg;
  logic [15:0] irq_enable_high_reg;
  logic [15:0] per_input_latch_reset_reg;

  logic wr_global;
  logic wr_latch_reset;

  assign wr_global = io_req.wr && (io_req.addr == iir_pkg::OFS_GLOBAL_GROUP_CONTROL);
  assign wr_latch_reset = io_req.wr && (io_req.addr == iir_pkg::OFS_PER_INPUT_LATCH_RESET);

  // Every register is a full word; writes to read-only or unused offsets are
  // dropped without any signalling. The latch reset register starts at all
  // ones, so a first write of a one cannot clear a latch on its own.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      global_group_control_reg <= iir_pkg::RST_GLOBAL;
      group_irq_select_reg <= iir_pkg::RST_WORD;
      per_input_irq_gate_reg <= iir_pkg::RST_WORD;
      single_irq_select_reg <= '0;
      irq_enable_low_reg <= iir_pkg::RST_WORD;
      irq_enable_high_reg <= iir_pkg::RST_WORD;
      per_input_latch_reset_reg <= iir_pkg::RST_LATCH_RESET;
    end
    else if (io_req.wr)
    begin
      unique case (io_req.addr)
        iir_pkg::OFS_GLOBAL_GROUP_CONTROL:
          global_group_control_reg <= io_req.wdata;
        iir_pkg::OFS_GROUP_IRQ_SELECT:
          group_irq_select_reg <= io_req.wdata;
        iir_pkg::OFS_PER_INPUT_IRQ_GATE:
          per_input_irq_gate_reg <= io_req.wdata;
        iir_pkg::OFS_SINGLE_IRQ_SELECT_0:
          single_irq_select_reg[15:0] <= io_req.wdata;
        iir_pkg::OFS_SINGLE_IRQ_SELECT_1:
          single_irq_select_reg[31:16] <= io_req.wdata;
        iir_pkg::OFS_SINGLE_IRQ_SELECT_2:
          single_irq_select_reg[47:32] <= io_req.wdata;
        iir_pkg::OFS_IRQ_ENABLE_LOW:
          irq_enable_low_reg <= io_req.wdata;
        iir_pkg::OFS_IRQ_ENABLE_HIGH:
          irq_enable_high_reg <= io_req.wdata;
        iir_pkg::OFS_PER_INPUT_LATCH_RESET:
          per_input_latch_reset_reg <= io_req.wdata;
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latch clear pulses: a clear fires on a write that moves a bit from 0 to 1.

  logic [NUM_INPUTS-1:0] clear_single;
  logic clear_low;
  logic clear_high;
  logic [NUM_INPUTS-1:0] clear_any;

  assign clear_single = wr_latch_reset
    ? (io_req.wdata[NUM_INPUTS-1:0] & ~per_input_latch_reset_reg[NUM_INPUTS-1:0])
    : '0;
  assign clear_low = wr_global
    && io_req.wdata[iir_pkg::BIT_LOW_GROUP_LATCH_RESET]
    && !global_group_control_reg[iir_pkg::BIT_LOW_GROUP_LATCH_RESET];
  assign clear_high = wr_global
    && io_req.wdata[iir_pkg::BIT_HIGH_GROUP_LATCH_RESET]
    && !global_group_control_reg[iir_pkg::BIT_HIGH_GROUP_LATCH_RESET];
  assign clear_any = clear_single | {{HALF{clear_high}}, {HALF{clear_low}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Event latches and routing.

  logic [2:0] low_group_sel;
  logic [2:0] high_group_sel;
  logic low_group_en;
  logic high_group_en;
  logic [NUM_INPUTS-1:0] input_enable;
  logic [NUM_INPUTS-1:0] armed;
  logic [NUM_INPUTS-1:0] latch_reg;

  // Group select word: bits 2:0 pick the low group line and bit 3 enables it,
  // bits 6:4 pick the high group line and bit 7 enables it.
  assign low_group_sel = group_irq_select_reg[iir_pkg::POS_LOW_GROUP_SEL +: 3];
  assign high_group_sel = group_irq_select_reg[iir_pkg::POS_HIGH_GROUP_SEL +: 3];
  assign low_group_en = group_irq_select_reg[iir_pkg::BIT_LOW_GROUP_EN];
  assign high_group_en = group_irq_select_reg[iir_pkg::BIT_HIGH_GROUP_EN];
  // Bit n of each enable register arms input n of its group. Software that
  // re-enables an input whose latch is still set sees one extra request.
  assign input_enable = {irq_enable_high_reg[HALF-1:0], irq_enable_low_reg[HALF-1:0]};

  logic [NUM_LINES-1:0] line_hit [NUM_INPUTS];

  genvar i;
  generate
    for (i = 0; i < NUM_INPUTS; i++)
    begin : g_input
      logic grp_en;
      logic [2:0] grp_sel;
      logic [2:0] own_sel;

      assign grp_en = (i < HALF) ? low_group_en : high_group_en;
      assign grp_sel = (i < HALF) ? low_group_sel : high_group_sel;
      assign own_sel = single_irq_select_reg[3*i +: 3];
      assign armed[i] = input_enable[i] && (per_input_irq_gate_reg[i] || grp_en);

      // A new edge in the clearing cycle wins, so no event is lost.
      // A set latch ignores the pin falling again and waits for software.
      always_ff @(posedge clock)
      begin
        if (!reset_n)
          latch_reg[i] <= 1'h0;
        else if (iso_rise[i] && armed[i])
          latch_reg[i] <= 1'h1;
        else if (clear_any[i])
          latch_reg[i] <= 1'h0;
      end

      for (genvar k = 0; k < NUM_LINES; k++)
      begin : g_line
        assign line_hit[i][k] = latch_reg[i] && input_enable[i]
          && ((per_input_irq_gate_reg[i] && (own_sel == 3'(k)))
          || (grp_en && (grp_sel == 3'(k))));
      end
    end
  endgenerate

  // Several inputs may share one line and their requests are merged here, so
  // two sources on one line never fight inside the block. Software must still
  // keep the group lines apart from each other and from the single selects.
  logic [NUM_LINES-1:0] line_req;

  always_comb
  begin
    line_req = '0;
    for (int n = 0; n < NUM_INPUTS; n++)
      line_req = line_req | line_hit[n];
  end

  // Only the enable toggles; the driven level stays at the active level.
  // The host side pulls a released line back to its inactive level.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      irq_oe <= '0;
      irq_o <= '0;
    end
    else
    begin
      irq_oe <= line_req;
      irq_o <= '1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Digital outputs and read port.

  logic wr_dig;

  assign wr_dig = io_req.wr && (io_req.addr == iir_pkg::OFS_DIGITAL_IO_PORT);

  // The output lines load straight from the host write, so a written word
  // shows on the pins right after the write edge.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      dig_out <= iir_pkg::RST_WORD;
    else if (wr_dig)
      dig_out <= io_req.wdata;
  end

  // Reads of the digital port return the synchronised pin levels, not the
  // last value written; the status words show the latches and input levels.
  logic [15:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    unique case (io_req.addr)
      iir_pkg::OFS_GLOBAL_GROUP_CONTROL: rd_mux = global_group_control_reg;
      iir_pkg::OFS_GROUP_IRQ_SELECT: rd_mux = group_irq_select_reg;
      iir_pkg::OFS_PER_INPUT_IRQ_GATE: rd_mux = per_input_irq_gate_reg;
      iir_pkg::OFS_SINGLE_IRQ_SELECT_0: rd_mux = single_irq_select_reg[15:0];
      iir_pkg::OFS_SINGLE_IRQ_SELECT_1: rd_mux = single_irq_select_reg[31:16];
      iir_pkg::OFS_SINGLE_IRQ_SELECT_2: rd_mux = single_irq_select_reg[47:32];
      iir_pkg::OFS_IRQ_ENABLE_LOW: rd_mux = irq_enable_low_reg;
      iir_pkg::OFS_IRQ_ENABLE_HIGH: rd_mux = irq_enable_high_reg;
      iir_pkg::OFS_PER_INPUT_LATCH_RESET: rd_mux = per_input_latch_reset_reg;
      iir_pkg::OFS_DIGITAL_IO_PORT: rd_mux = dig_level;
      iir_pkg::OFS_LATCH_STATUS: rd_mux = 16'(latch_reg);
      iir_pkg::OFS_INPUT_LEVEL: rd_mux = 16'(iso_level);
      default: rd_mux = '0;
    endcase
  end

  // Read data stands for one cycle with its valid flag and is zero otherwise.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      io_rdata <= '0;
      io_rvalid <= 1'h0;
    end
    else
    begin
      io_rdata <= io_req.rd ? rd_mux : 16'h0000;
      io_rvalid <= io_req.rd;
    end
  end

endmodule

// *** iir_router_monitor.sv ***
`timescale 1ns/1ns
module iir_router_monitor #(
  parameter int unsigned NUM_INPUTS = 16,
  parameter int unsigned NUM_LINES = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Host cycle
  input wire iir_pkg::iir_io_req_t io_req,
  input wire logic [15:0] io_rdata,
  input wire logic io_rvalid,
  // Pins and lines
  input wire logic [NUM_INPUTS-1:0] iso_in,
  input wire logic [15:0] dig_in,
  input wire logic [15:0] dig_out,
  input wire logic [NUM_LINES-1:0] irq_o,
  input wire logic [NUM_LINES-1:0] irq_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [NUM_INPUTS-1:0] iso_q;
  logic [3:0] quiet;
  logic dio_wr;
  assign dio_wr = io_req.wr && io_req.addr == iir_pkg::OFS_DIGITAL_IO_PORT;
  ////////////////////////////////////////////////////////////////////////////
  // Counts cycles since the last pin change or host write.
  always_ff @(posedge clock)
  begin
    iso_q <= iso_in;
    if (!reset_n || iso_in != iso_q || io_req.wr)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (io_req.rd |=> io_rvalid)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (io_rvalid |-> $past(io_req.rd))
    else $error("answer without read strobe");
  a_idle_rdata: assert property (!io_rvalid |-> io_rdata == 16'h0000)
    else $error("read data not zero while idle");
  a_dout_write: assert property (dio_wr |=> dig_out == $past(io_req.wdata))
    else $error("digital outputs do not follow write");
  a_dout_steady: assert property (!dio_wr |=> $stable(dig_out))
    else $error("digital outputs changed without write");
  a_oe_drive: assert property (|irq_oe |-> (irq_oe & ~irq_o) == '0)
    else $error("enabled line not driven active");
  a_oe_keep: assert property (|($past(irq_oe) & ~irq_oe) |-> $past(io_req.wr, 2))
    else $error("request dropped without host write");
  a_oe_cause: assert property (|(irq_oe & ~$past(irq_oe)) |-> quiet < 4'hc)
    else $error("request raised without pin edge or write");
  cover property (io_rvalid && io_rdata != 16'h0000);
  cover property (|irq_oe);
  cover property (|($past(irq_oe) & ~irq_oe));
endmodule
bind iir_router iir_router_monitor #(.NUM_INPUTS(NUM_INPUTS), .NUM_LINES(NUM_LINES)) u_mon (
  .clock(clock), .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .iso_in(iso_in), .dig_in(dig_in), .dig_out(dig_out),
  .irq_o(irq_o), .irq_oe(irq_oe));

// *** iir_router_test.sv ***
`timescale 1ns/1ns
module iir_router_test;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  iir_pkg::iir_io_req_t io_req = '0;
  logic [15:0] io_rdata;
  logic io_rvalid;
  logic [15:0] iso_in = 16'h0000;
  logic [15:0] dig_in = 16'h0000;
  logic [15:0] dig_out;
  logic [7:0] irq_o;
  logic [7:0] irq_oe;
  logic [7:0] irq_line;
  int miscompares = 0;
  int total_checks = 0;
  always #2 clock = ~clock;
  iir_router u_dut (.clock(clock), .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .iso_in(iso_in), .dig_in(dig_in), .dig_out(dig_out),
    .irq_o(irq_o), .irq_oe(irq_oe));
  iir_host_model u_host (.irq_o(irq_o), .irq_oe(irq_oe), .irq_line(irq_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check16(input string name, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check8(input string name, input logic [7:0] e);
    total_checks++;
    if (irq_line !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, irq_line);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    io_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clock);
    io_req <= '0;
  endtask
  task automatic rdchk(input string name, input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    io_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    io_req <= '0;
    #1;
    check16(name, e, io_rdata);
    check16("rvalid", 16'h0001, {15'h0000, io_rvalid});
  endtask
  task automatic pulse(input logic [15:0] m);
    @(posedge clock);
    iso_in <= m;
    repeat (6) @(posedge clock);
    iso_in <= 16'h0000;
    repeat (10) @(posedge clock);
    #1;
  endtask
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Places line k in the three-bit field of input i across the three select words.
  function automatic logic [47:0] sel_map(int i, int k);
    return 48'(k) << (3 * i);
  endfunction
  // Each group raises its own line when any of its inputs has a set latch.
  function automatic logic [7:0] exp_shared(int a, int b, logic [15:0] m);
    return ((|m[7:0]) ? 8'(1 << a) : 8'h00) | ((|m[15:8]) ? 8'(1 << b) : 8'h00);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] v;
    logic [47:0] s;
    int i;
    int a;
    int b;
    void'($urandom(5624));
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    rdchk("global", 5'h02, 16'h0000);
    rdchk("group", 5'h04, 16'h0000);
    rdchk("gate", 5'h06, 16'h0000);
    rdchk("unmapped", 5'h18, 16'h0000);
    repeat (8)
    begin
      v = 16'($urandom);
      wr(5'h14, v);
      #1 check16("dig_out", v, dig_out);
      @(posedge clock);
      dig_in <= ~v;
      iso_in <= v;
      repeat (6) @(posedge clock);
      rdchk("dig_in", 5'h14, ~v);
      rdchk("iso_level", 5'h1e, v);
    end
    @(posedge clock);
    iso_in <= 16'h0000;
    repeat (6) @(posedge clock);
    for (int k = 0; k < 8; k++)
    begin
      i = $urandom_range(15);
      s = sel_map(i, k);
      wr(5'h0e, (i < 8) ? 16'(1 << i) : 16'h0000);
      wr(5'h10, (i >= 8) ? 16'(1 << (i - 8)) : 16'h0000);
      wr(5'h06, 16'(1 << i));
      wr(5'h08, s[15:0]);
      wr(5'h0a, s[31:16]);
      wr(5'h0c, s[47:32]);
      pulse(16'(1 << i));
      check8("single", 8'(1 << k));
      rdchk("latch", 5'h1c, 16'(1 << i));
      wr(5'h12, ~16'(1 << i));
      wr(5'h12, 16'hffff);
      repeat (2) @(posedge clock);
      #1 check8("single_clr", 8'h00);
    end
    wr(5'h0e, 16'h0000);
    wr(5'h06, 16'h00ff);
    pulse(16'h00ff);
    check8("disabled", 8'h00);
    wr(5'h0e, 16'h00ff);
    wr(5'h10, 16'h00ff);
    wr(5'h06, 16'h0000);
    pulse(16'hffff);
    check8("ungated", 8'h00);
    rdchk("ungated_latch", 5'h1c, 16'h0000);
    a = $urandom_range(7);
    b = (a + 1 + $urandom_range(6)) % 8;
    wr(5'h04, 16'h0088 | 16'(a) | 16'(b << 4));
    v = 16'($urandom) | 16'h0101;
    pulse(v);
    check8("shared", exp_shared(a, b, v));
    wr(5'h02, 16'h0000);
    wr(5'h02, 16'h0001);
    repeat (2) @(posedge clock);
    #1 check8("low_clr", exp_shared(a, b, v & 16'hff00));
    rdchk("low_latch", 5'h1c, v & 16'hff00);
    wr(5'h02, 16'h0000);
    wr(5'h02, 16'h0002);
    repeat (2) @(posedge clock);
    #1 check8("high_clr", 8'h00);
    stop_test;
  end
  initial
  begin
    #40000;
    miscompares++;
    stop_test;
  end
endmodule
